// File: src/nvc_pkg.sv
/*
  Package for the non-volatile data memory controller: register indices,
  control field positions, reset values, cycle timing and the carrier types.
  Assumes a 10 MHz system clock; the erase and write counts derive from that period.
*/
package nvc_pkg;

  // Register indices on the special function register port
  localparam logic [1:0] NVC_IDX_ADDR_LOW = 2'h0;
  localparam logic [1:0] NVC_IDX_ADDR_HIGH = 2'h1;
  localparam logic [1:0] NVC_IDX_DATA = 2'h2;
  localparam logic [1:0] NVC_IDX_CTRL = 2'h3;

  // Reset values
  localparam logic [7:0] NVC_RST_BYTE = 8'h00;
  localparam logic [2:0] NVC_RST_HIGH = 3'h0;

  // Address high masks for the two variants
  localparam logic [2:0] NVC_HI_MASK_SMALL = 3'h3;
  localparam logic [2:0] NVC_HI_MASK_LARGE = 3'h7;
  localparam int NVC_HI_W_SMALL = 2;
  localparam int NVC_HI_W_LARGE = 3;

  // Page geometry
  localparam int NVC_PAGE_BYTES = 16;
  localparam logic [3:0] NVC_NIB_LAST = 4'hF;
  localparam logic [3:0] NVC_NIB_ONE = 4'h1;

  // Timing, in ns as printed, and derived cycle counts
  localparam int NVC_CLK_PERIOD_NS = 100;
  localparam int NVC_ERASE_FAST_NS = 3200000;
  localparam int NVC_WRITE_FAST_NS = 2200000;
  localparam int NVC_ERASE_SLOW_NS = 3700000;
  localparam int NVC_WRITE_SLOW_NS = 3000000;
  localparam int NVC_ERASE_FAST_CYC =
    (NVC_ERASE_FAST_NS + NVC_CLK_PERIOD_NS - 1) / NVC_CLK_PERIOD_NS;
  localparam int NVC_WRITE_FAST_CYC =
    (NVC_WRITE_FAST_NS + NVC_CLK_PERIOD_NS - 1) / NVC_CLK_PERIOD_NS;
  localparam int NVC_ERASE_SLOW_CYC =
    (NVC_ERASE_SLOW_NS + NVC_CLK_PERIOD_NS - 1) / NVC_CLK_PERIOD_NS;
  localparam int NVC_WRITE_SLOW_CYC =
    (NVC_WRITE_SLOW_NS + NVC_CLK_PERIOD_NS - 1) / NVC_CLK_PERIOD_NS;
  localparam logic [15:0] NVC_READ_CYC = 16'h0002;
  localparam logic [15:0] NVC_CNT_ONE = 16'h0001;
  localparam int NVC_CNT_MAX = 65535;

  // Control register, bit 7 down to bit 0
  typedef struct packed {
    logic cycle_time_select;
    logic wipe_permit;
    logic wipe_trigger;
    logic page_mode;
    logic store_permit;
    logic store_trigger;
    logic fetch_permit;
    logic fetch_trigger;
  } nvc_ctrl_t;

  // One register access from the core
  typedef struct packed {
    logic wr;
    logic [1:0] sel;
    logic [7:0] wdata;
  } nvc_reg_req_t;

  typedef enum logic [1:0] {
    NVC_IDLE,
    NVC_ERASE,
    NVC_WRITE,
    NVC_READ
  } nvc_state_e_t;

  // All state of the controller
  typedef struct packed {
    nvc_ctrl_t ctrl;
    logic [2:0] addr_high;
    logic [7:0] addr_low;
    logic [7:0] data;
    logic [NVC_PAGE_BYTES-1:0][7:0] page_buf;
    logic [NVC_PAGE_BYTES-1:0] page_tag;
    logic page_full;
    nvc_state_e_t state;
    logic [15:0] cnt;
    logic [7:0] rdata;
    logic done;
    logic mf_req;
    logic [1:0] sub_sync;
  } nvc_state_t;

endpackage

// File: src/nvc_ctrl.sv
/*
  Controller for the on-chip byte-wide non-volatile data memory: address,
  data and control registers, byte and page read, write and erase, a
  16-byte page buffer and the completion flag. Holds the memory array.
  Assumes a core that writes one register per cycle on the register port,
  a sub-clock stable level from another domain, and a flag clear strobe.
  Timer counts are whole system clocks rounded up from the nominal times;
  a read cycle is a fixed short count and does not wait for the sub clock.
  The erase and write timers pause while the sub clock is not stable, so
  software that ignores that level sees a longer cycle, never a lost one.
  Software is expected to let a cycle end before it touches a register.
*/
// Behaviour
// - small variant: high address holds bits 9..8
// - large variant: high address holds bits 10..8
// - timing select picks erase and write durations
// - erase needs wipe permit; cleared after erase
// - wipe trigger starts erase only if permitted
// - mode bit selects byte or 16-byte page
// - write needs store permit; cleared after write
// - store trigger starts write only if permitted
// - reads need fetch permit set
// - fetch trigger starts read only if permitted
// - byte read leaves byte in data register
// - page read clears trigger then advances address
// - page nibble increments, saturates at 0FH
// - reset and wipe or store permit falling edge clear buffer
// - page erase data write tags address, advances
// - page erase covers at most 16 tagged bytes
// - erased bytes read back as zero
// - erase or write end sets done and multi-function flags
// - page writes past boundary are ignored
// - byte write erases target before programming
`timescale 1ns/1ps
module nvc_ctrl
  import nvc_pkg::*;
#(
  parameter int HI_W = NVC_HI_W_SMALL,
  parameter int ERASE_FAST_CYC = NVC_ERASE_FAST_CYC,
  parameter int WRITE_FAST_CYC = NVC_WRITE_FAST_CYC,
  parameter int ERASE_SLOW_CYC = NVC_ERASE_SLOW_CYC,
  parameter int WRITE_SLOW_CYC = NVC_WRITE_SLOW_CYC
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire nvc_reg_req_t reg_req,
  output logic [7:0] reg_rdata,
  input wire logic sub_clk_stable,
  input wire logic done_clr,
  output logic nv_done_flag,
  output logic mf_req,
  output logic busy
);

  // Array address width follows the variant: ten bits for the small part,
  // eleven for the large one; the page field is everything above bit 3
  localparam int AW = 8 + HI_W;
  localparam int DEPTH = 1 << AW;

  // Elaboration-time checks on the parameters; only the two variants are
  // served, since the high address mask has three bits at most
  if (HI_W != NVC_HI_W_SMALL && HI_W != NVC_HI_W_LARGE) begin : g_bad_hi
    $error("HI_W must be 2 or 3");
  end
  // The slot index is the low address nibble, so the buffer must match it
  if (NVC_PAGE_BYTES != int'(NVC_NIB_LAST) + 1) begin : g_bad_page
    $error("page buffer must cover every nibble value");
  end
  // A read count of zero would wrap below zero and take 65536 cycles to end
  if (NVC_READ_CYC == 16'h0000) begin : g_bad_rd
    $error("read cycle count must be nonzero");
  end
  // Cycle counts must fit the 16-bit timer and never be zero
  if (ERASE_FAST_CYC < 1 || ERASE_FAST_CYC > NVC_CNT_MAX ||
      WRITE_FAST_CYC < 1 || WRITE_FAST_CYC > NVC_CNT_MAX ||
      ERASE_SLOW_CYC < 1 || ERASE_SLOW_CYC > NVC_CNT_MAX ||
      WRITE_SLOW_CYC < 1 || WRITE_SLOW_CYC > NVC_CNT_MAX) begin : g_bad_t
    $error("cycle counts must lie in 1..65535");
  end

  // Variant mask, and cycle lengths narrowed to the timer width
  localparam logic [2:0] HI_MASK =
    (HI_W == NVC_HI_W_LARGE) ? NVC_HI_MASK_LARGE : NVC_HI_MASK_SMALL;
  localparam logic [15:0] E_FAST = 16'(ERASE_FAST_CYC);
  localparam logic [15:0] W_FAST = 16'(WRITE_FAST_CYC);
  localparam logic [15:0] E_SLOW = 16'(ERASE_SLOW_CYC);
  localparam logic [15:0] W_SLOW = 16'(WRITE_SLOW_CYC);

  // Nonvolatile contents: no reset, they survive power-up by nature.
  // The array is read combinationally at the current address; a real
  // macro needs settling time, which is what the read cycle stands for
  logic [7:0] mem [0:DEPTH-1];

  // Whole controller state, its next value and the array port wires
  nvc_state_t s_r;
  nvc_state_t s_nxt;
  logic [10:0] full_addr;
  logic [7:0] mem_rd;
  logic mem_we;
  logic mem_zero;

  // Register read mux, shared by the read port; unimplemented high
  // address bits read as zero whatever software wrote there
  function automatic logic [7:0] reg_view(input nvc_state_t s,
                                          input logic [1:0] sel);
    logic [7:0] v;
    v = NVC_RST_BYTE;
    case (sel)
      NVC_IDX_ADDR_LOW: v = s.addr_low;
      NVC_IDX_ADDR_HIGH: v = {5'h00, s.addr_high & HI_MASK};
      NVC_IDX_DATA: v = s.data;
      NVC_IDX_CTRL: v = s.ctrl;
      default: v = NVC_RST_BYTE;
    endcase
    return v;
  endfunction

  // Page address of buffer slot i within the current page; the page field
  // comes from the live address, which only the nibble ever moves
  function automatic logic [AW-1:0] page_index(input logic [10:0] a,
                                               input logic [3:0] i);
    logic [10:0] p;
    p = {a[10:4], i};
    return p[AW-1:0];
  endfunction

  // Duration of an erase or write cycle, chosen by the timing bit as it
  // is written together with the trigger
  function automatic logic [15:0] cycle_len(input logic slow,
                                            input logic erase);
    logic [15:0] c;
    c = erase ? (slow ? E_SLOW : E_FAST) : (slow ? W_SLOW : W_FAST);
    return c;
  endfunction

  // Current array address; the mask keeps the small variant's top bit zero
  assign full_addr = {s_r.addr_high, s_r.addr_low};
  assign mem_rd = mem[full_addr[AW-1:0]];

  // Next-state logic for the whole controller
  always_comb begin
    // Scratch values, each given a value before any use
    logic idle;
    logic finish;
    logic [3:0] nib;
    nvc_ctrl_t wc;
    idle = 1'b0;
    finish = 1'b0;
    nib = s_r.addr_low[3:0];
    wc = reg_req.wdata;
    s_nxt = s_r;
    mem_we = 1'b0;
    mem_zero = 1'b0;
    s_nxt.mf_req = 1'b0;
    // Sub clock level crosses domains through two flops; only the second
    // is ever read, so a metastable first stage never reaches the timer
    s_nxt.sub_sync = {s_r.sub_sync[0], sub_clk_stable};
    // Read data is the register as it stood before this edge, so a write
    // and a read of one register in one cycle return the old value
    s_nxt.rdata = reg_view(s_r, reg_req.sel);
    idle = (s_r.state == NVC_IDLE);

    // Timed cycles count only while the sub clock is stable, since the
    // real array timer runs from it; reads do not depend on it. A cycle
    // pauses rather than aborts, so its commit still lands, only later
    if (!idle) begin
      if (s_r.state == NVC_READ || s_r.sub_sync[1]) begin
        if (s_r.cnt == NVC_CNT_ONE) begin
          finish = 1'b1;
        end else begin
          s_nxt.cnt = s_r.cnt - NVC_CNT_ONE;
        end
      end
    end

    // Completion of the running cycle; only one cycle runs at a time, so
    // the case below sees every possible source
    if (finish) begin
      s_nxt.state = NVC_IDLE;
      case (s_r.state)
        NVC_ERASE: begin
          // Zeros go in; the permit drop below also empties the buffer
          mem_we = 1'b1;
          mem_zero = 1'b1;
          s_nxt.ctrl.wipe_trigger = 1'b0;
          s_nxt.ctrl.wipe_permit = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.mf_req = 1'b1;
        end
        NVC_WRITE: begin
          // Byte write lands erase and program in one commit
          mem_we = 1'b1;
          s_nxt.ctrl.store_trigger = 1'b0;
          s_nxt.ctrl.store_permit = 1'b0;
          s_nxt.done = 1'b1;
          s_nxt.mf_req = 1'b1;
        end
        NVC_READ: begin
          // The byte lands first; page mode then steps the nibble
          s_nxt.data = mem_rd;
          s_nxt.ctrl.fetch_trigger = 1'b0;
          if (s_r.ctrl.page_mode && nib != NVC_NIB_LAST) begin
            s_nxt.addr_low[3:0] = nib + NVC_NIB_ONE;
          end
        end
        default: s_nxt.state = NVC_IDLE;
      endcase
    end

    // Register writes; while busy everything is held stable, address
    // included, so a cycle always commits where it started
    if (reg_req.wr && idle) begin
      case (reg_req.sel)
        NVC_IDX_ADDR_LOW: s_nxt.addr_low = reg_req.wdata;
        NVC_IDX_ADDR_HIGH: begin
          // Bits beyond the variant are dropped on the way in
          s_nxt.addr_high = reg_req.wdata[2:0] & HI_MASK;
        end
        NVC_IDX_DATA: begin
          // Page mode: load and tag the slot, then step the low nibble.
          // The nibble stops at its last value and the full flag drops
          // every later write, data register included
          if (!s_r.ctrl.page_mode) begin
            s_nxt.data = reg_req.wdata;
          end else if (!s_r.page_full) begin
            s_nxt.data = reg_req.wdata;
            s_nxt.page_buf[nib] = reg_req.wdata;
            s_nxt.page_tag[nib] = 1'b1;
            if (nib == NVC_NIB_LAST) begin
              s_nxt.page_full = 1'b1;
            end else begin
              s_nxt.addr_low[3:0] = nib + NVC_NIB_ONE;
            end
          end
        end
        NVC_IDX_CTRL: begin
          s_nxt.ctrl.cycle_time_select = wc.cycle_time_select;
          s_nxt.ctrl.page_mode = wc.page_mode;
          s_nxt.ctrl.wipe_permit = wc.wipe_permit;
          s_nxt.ctrl.store_permit = wc.store_permit;
          s_nxt.ctrl.fetch_permit = wc.fetch_permit;
          // Triggers come up only through a permitted start below
          s_nxt.ctrl.wipe_trigger = 1'b0;
          s_nxt.ctrl.store_trigger = 1'b0;
          s_nxt.ctrl.fetch_trigger = 1'b0;
          // A trigger counts only when its permit was already set; erase
          // wins over write, write over read, if software breaks the
          // one-bit-per-write habit. The priority is a guard only; software
          // must never lean on it. A start keeps its stored permit set
          // until the cycle ends
          if (wc.wipe_trigger && s_r.ctrl.wipe_permit) begin
            s_nxt.ctrl.wipe_trigger = 1'b1;
            s_nxt.ctrl.wipe_permit = 1'b1;
            s_nxt.state = NVC_ERASE;
            s_nxt.cnt = cycle_len(wc.cycle_time_select, 1'b1);
          end else if (wc.store_trigger && s_r.ctrl.store_permit) begin
            s_nxt.ctrl.store_trigger = 1'b1;
            s_nxt.ctrl.store_permit = 1'b1;
            s_nxt.state = NVC_WRITE;
            s_nxt.cnt = cycle_len(wc.cycle_time_select, 1'b0);
          end else if (wc.fetch_trigger && s_r.ctrl.fetch_permit) begin
            s_nxt.ctrl.fetch_trigger = 1'b1;
            s_nxt.ctrl.fetch_permit = 1'b1;
            s_nxt.state = NVC_READ;
            s_nxt.cnt = NVC_READ_CYC;
          end
        end
        default: s_nxt.addr_low = s_r.addr_low;
      endcase
    end

    // Either permit falling from one to zero empties the page buffer.
    // The read permit owns no buffer, so dropping it leaves loaded data
    if ((s_r.ctrl.wipe_permit && !s_nxt.ctrl.wipe_permit) ||
        (s_r.ctrl.store_permit && !s_nxt.ctrl.store_permit)) begin
      s_nxt.page_buf = '0;
      s_nxt.page_tag = '0;
      s_nxt.page_full = 1'b0;
    end

    // Completion flag: software clears it, a new completion wins, so a
    // clear that races an event never loses it
    if (done_clr && !s_nxt.mf_req) begin
      s_nxt.done = 1'b0;
    end
  end

  // State register; the buffer clears at reset as well. The clock enable
  // gates the synchroniser too, so a frozen block resumes where it stopped
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      // The array itself is nonvolatile and keeps its contents
      s_r.ctrl <= nvc_ctrl_t'(NVC_RST_BYTE);
      s_r.addr_high <= NVC_RST_HIGH;
      s_r.addr_low <= NVC_RST_BYTE;
      s_r.data <= NVC_RST_BYTE;
      s_r.page_buf <= '0;
      s_r.page_tag <= '0;
      s_r.page_full <= 1'b0;
      s_r.state <= NVC_IDLE;
      s_r.cnt <= 16'h0000;
      s_r.rdata <= NVC_RST_BYTE;
      s_r.done <= 1'b0;
      s_r.mf_req <= 1'b0;
      s_r.sub_sync <= 2'h0;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  // Array commit at the end of an erase or write cycle. Page mode touches
  // only tagged slots of the current page, so one erase covers at most
  // one page; byte write lands erase and program in the same commit.
  // Erase commits zeros in place of the buffer, so dummy bytes loaded to
  // tag slots never reach the array
  always_ff @(posedge clk_sys) begin
    if (ce && mem_we) begin
      if (s_r.ctrl.page_mode) begin
        // Slots outside the tag set keep their old contents
        for (int i = 0; i < NVC_PAGE_BYTES; i++) begin
          if (s_r.page_tag[i]) begin
            mem[page_index(full_addr, 4'(i))] <=
              mem_zero ? NVC_RST_BYTE : s_r.page_buf[i];
          end
        end
      end else begin
        mem[full_addr[AW-1:0]] <= mem_zero ? NVC_RST_BYTE : s_r.data;
      end
    end
  end

  // Data outputs come straight from state flops; busy decodes the state
  // register, so it rises on the edge that takes the trigger
  assign reg_rdata = s_r.rdata;
  assign nv_done_flag = s_r.done;
  assign mf_req = s_r.mf_req;
  assign busy = (s_r.state != NVC_IDLE);

endmodule

// File: bench/nvc_ctrl_chk.sv
/*
  Port checker for the data memory controller.
  Assumes it is bound to nvc_ctrl and sees only that module's ports.
*/
`timescale 1ns/1ps
module nvc_ctrl_chk
  import nvc_pkg::*;
#(
  parameter int HI_W = 2
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ce,
  input wire nvc_reg_req_t reg_req,
  input wire logic [7:0] reg_rdata,
  input wire logic sub_clk_stable,
  input wire logic done_clr,
  input wire logic nv_done_flag,
  input wire logic mf_req,
  input wire logic busy
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Completion pulse is single, follows a busy cycle, raises the flag
  mf_pulse_a: assert property (mf_req && ce |=> !mf_req)
    else $error("completion pulse too long");
  done_set_a: assert property (mf_req |-> nv_done_flag && !busy)
    else $error("completion without flag or still busy");
  mf_cause_a: assert property (mf_req && $past(ce) |-> $past(busy))
    else $error("completion pulse without a running cycle");
  flag_cause_a: assert property ($rose(nv_done_flag) |-> mf_req)
    else $error("flag rose without completion");
  // Flag is sticky until software clears it
  done_hold_a: assert property (
    nv_done_flag && !(done_clr && ce) |=> nv_done_flag)
    else $error("flag dropped without clear");
  done_clr_a: assert property (
    done_clr && ce && !busy |=> !nv_done_flag)
    else $error("flag not cleared");
  idle_quiet_a: assert property (!busy && ce |=> !mf_req)
    else $error("completion while idle");
  // A frozen clock enable must hold busy, the done flag and the pulse
  ce_freeze_a: assert property (!ce |=> $stable(busy) &&
    $stable(nv_done_flag) && $stable(mf_req))
    else $error("outputs moved while disabled");
  high_zero_a: assert property (
    ce && reg_req.sel == NVC_IDX_ADDR_HIGH |=> (reg_rdata >> HI_W) == 0)
    else $error("unused high address bits not zero");
  cov_done_c: cover property (mf_req);
  cov_busy_c: cover property ($fell(busy));
  cov_freeze_c: cover property (!ce && busy);
endmodule

bind nvc_ctrl nvc_ctrl_chk #(.HI_W(HI_W)) chk_u (.clk_sys(clk_sys),
  .rstn(rstn), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
  .sub_clk_stable(sub_clk_stable), .done_clr(done_clr),
  .nv_done_flag(nv_done_flag), .mf_req(mf_req), .busy(busy));

// File: bench/nvc_ctrl_bench.sv
/*
  Self-checking bench for the data memory controller.
  Assumes short cycle parameters; expectations use their differences.
*/
`timescale 1ns/1ps
module nvc_ctrl_bench
  import nvc_pkg::*;
;
  logic clk_sys, rstn, ce, sub_clk_stable, done_clr, nv_done_flag;
  logic mf_req, busy;
  nvc_reg_req_t reg_req;
  logic [7:0] reg_rdata, v;
  logic [7:0] trg [3] = '{8'h01, 8'h04, 8'h20};
  logic [15:0] mf_cnt = 16'h0000;
  int fail_count = 0;
  int num_checks = 0;
  int n0, n1, n2;

  nvc_ctrl #(.HI_W(2), .ERASE_FAST_CYC(20), .WRITE_FAST_CYC(10),
    .ERASE_SLOW_CYC(25), .WRITE_SLOW_CYC(15)) dut_u (.clk_sys(clk_sys),
    .rstn(rstn), .ce(ce), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .sub_clk_stable(sub_clk_stable), .done_clr(done_clr),
    .nv_done_flag(nv_done_flag), .mf_req(mf_req), .busy(busy));

  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Count completion pulses so each cycle end is seen exactly once
  always @(posedge clk_sys) begin
    if (mf_req === 1'b1)
      mf_cnt <= mf_cnt + 16'h0001;
  end

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  // Strobe drops a cycle later, so back-to-back calls never collide
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    @(posedge clk_sys);
    reg_req <= '{1'b1, s, d};
    @(posedge clk_sys);
    reg_req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] s);
    @(posedge clk_sys);
    reg_req <= '{1'b0, s, 8'h00};
    @(posedge clk_sys);
    #1 v = reg_rdata;
  endtask

  task automatic idle(output int n);
    n = 0;
    do begin
      @(posedge clk_sys);
      #1 n++;
    end while (busy !== 1'b0 && n < 600);
    if (n >= 600) begin
      fail_count++;
      end_of_test();
    end
  endtask

  // Permit, then permit plus trigger; check control, flag, pulse count.
  // Nothing comes between the two writes, since the task issues them back to back
  task automatic run(input logic [7:0] p, t, c, input logic e,
    output int n);
    logic [15:0] m0;
    m0 = mf_cnt;
    wr(NVC_IDX_CTRL, p);
    wr(NVC_IDX_CTRL, p | t);
    idle(n);
    rd(NVC_IDX_CTRL);
    chk(v, c);
    chk(nv_done_flag, e);
    chk(mf_cnt - m0, e);
    @(posedge clk_sys);
    done_clr <= 1'b1;
    @(posedge clk_sys);
    done_clr <= 1'b0;
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    #3000000;
    fail_count++;
    end_of_test();
  end

  initial begin
    rstn = 1'b0;
    ce = 1'b1;
    reg_req = '0;
    sub_clk_stable = 1'b1;
    done_clr = 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(i[1:0]);
      chk(v, 16'h0000);
    end
    wr(NVC_IDX_ADDR_HIGH, 8'hFF);
    rd(NVC_IDX_ADDR_HIGH);
    chk(v, 16'h0003);
    wr(NVC_IDX_ADDR_HIGH, 8'h01);
    wr(NVC_IDX_ADDR_LOW, 8'h20);
    $display("test registers done");
    // Duration differences cancel the sync and start latency
    wr(NVC_IDX_DATA, 8'hA5);
    run(8'h08, 8'h04, 8'h00, 1'b1, n0);
    wr(NVC_IDX_DATA, 8'hA5);
    run(8'h88, 8'h04, 8'h80, 1'b1, n1);
    chk(16'(n1 - n0), 16'h0005);
    wr(NVC_IDX_DATA, 8'h00);
    run(8'h02, 8'h01, 8'h02, 1'b0, n2);
    rd(NVC_IDX_DATA);
    chk(v, 16'h00A5);
    run(8'h40, 8'h20, 8'h00, 1'b1, n2);
    chk(16'(n2 - n0), 16'h000A);
    run(8'hC0, 8'h20, 8'h80, 1'b1, n1);
    chk(16'(n1 - n2), 16'h0005);
    run(8'h02, 8'h01, 8'h02, 1'b0, n1);
    rd(NVC_IDX_DATA);
    chk(v, 16'h0000);
    wr(NVC_IDX_CTRL, 8'h00);
    foreach (trg[i]) begin
      wr(NVC_IDX_CTRL, trg[i]);
      rd(NVC_IDX_CTRL);
      chk(v, 16'h0000);
      chk(busy, 1'b0);
    end
    // Sub clock unstable for four synced edges pauses the write timer
    fork
      run(8'h08, 8'h04, 8'h00, 1'b1, n1);
      begin
        repeat (3) @(posedge clk_sys);
        sub_clk_stable <= 1'b0;
        repeat (4) @(posedge clk_sys);
        sub_clk_stable <= 1'b1;
      end
    join
    chk(16'(n1 - n0), 16'h0004);
    $display("test byte cycles done");
    // Page of three from 0x2D; the fourth write meets a full nibble
    wr(NVC_IDX_CTRL, 8'h10);
    wr(NVC_IDX_ADDR_LOW, 8'h2D);
    for (int k = 0; k < 4; k++)
      wr(NVC_IDX_DATA, 8'h31 + 8'(k));
    rd(NVC_IDX_ADDR_LOW);
    chk(v, 16'h002F);
    rd(NVC_IDX_DATA);
    chk(v, 16'h0033);
    run(8'h18, 8'h04, 8'h10, 1'b1, n0);
    wr(NVC_IDX_ADDR_LOW, 8'h2D);
    for (int k = 0; k < 4; k++) begin
      run(8'h12, 8'h01, 8'h12, 1'b0, n0);
      rd(NVC_IDX_DATA);
      chk(v, 16'h0031 + 16'(k > 2 ? 2 : k));
    end
    rd(NVC_IDX_ADDR_LOW);
    chk(v, 16'h002F);
    wr(NVC_IDX_ADDR_LOW, 8'h2E);
    wr(NVC_IDX_DATA, 8'h00);
    rd(NVC_IDX_ADDR_LOW);
    chk(v, 16'h002F);
    run(8'h50, 8'h20, 8'h10, 1'b1, n0);
    wr(NVC_IDX_ADDR_LOW, 8'h2D);
    for (int k = 0; k < 3; k++) begin
      run(8'h12, 8'h01, 8'h12, 1'b0, n0);
      rd(NVC_IDX_DATA);
      chk(v, k == 1 ? 16'h0000 : 16'h0031 + 16'(k));
    end
    $display("test page cycles done");
    // Writes during a cycle are dropped; a clock-enable gap rides along
    wr(NVC_IDX_CTRL, 8'h08);
    wr(NVC_IDX_CTRL, 8'h0C);
    wr(NVC_IDX_ADDR_LOW, 8'h55);
    @(posedge clk_sys);
    ce <= 1'b0;
    repeat (3) @(posedge clk_sys);
    ce <= 1'b1;
    idle(n0);
    rd(NVC_IDX_ADDR_LOW);
    chk(v, 16'h002F);
    chk(nv_done_flag, 1'b1);
    $display("test busy lockout done");
    end_of_test();
  end
endmodule
